// File: logic/sfd_pkg.sv
// constants, field layouts and types for the discoverable-parameter table responder
// assumes a 125 MHz system clock that oversamples the serial pins
package sfd_pkg;

    // ****************************************************************
    // serial protocol
    // ****************************************************************
    localparam logic [7:0] SFD_OP_READ_TABLE = 8'h5A;
    localparam int SFD_OP_BITS = 8;
    localparam int SFD_ADDR_BITS = 24;
    localparam int SFD_DUMMY_BITS = 8;
    localparam int SFD_BYTE_BITS = 8;

    // ****************************************************************
    // table layout
    // ****************************************************************
    localparam logic [23:0] SFD_BASIC_PTR = 24'h00_0030;
    localparam logic [23:0] SFD_TABLE_LAST = 24'h00_003B;
    localparam logic [7:0] SFD_BLANK_BYTE = 8'hFF;
    // first double-word fields
    localparam int SFD_ERASE_LSB = 0;
    localparam logic [1:0] SFD_ERASE_4K = 2'h1;
    localparam int SFD_GRAN_BIT = 2;
    localparam int SFD_VOL_BIT = 3;
    localparam int SFD_WEN_SEL_BIT = 4;
    localparam logic [2:0] SFD_RSVD_ONES = 3'h7;
    localparam logic [7:0] SFD_ERASE_OPCODE = 8'h20;
    localparam int SFD_F112_BIT = 16;
    localparam int SFD_ADDRW_LSB = 17;
    localparam logic [1:0] SFD_ADDRW_3B = 2'h0;
    localparam int SFD_DTR_BIT = 19;
    localparam int SFD_F122_BIT = 20;
    localparam int SFD_F144_BIT = 21;
    localparam int SFD_F114_BIT = 22;
    // multi-i/o read descriptions: wait [4:0], mode [7:5]
    localparam logic [4:0] SFD_WAIT_144 = 5'h04;
    localparam logic [2:0] SFD_MODE_144 = 3'h2;
    localparam logic [7:0] SFD_OPC_144 = 8'hEB;
    localparam logic [4:0] SFD_WAIT_114 = 5'h08;
    localparam logic [2:0] SFD_MODE_114 = 3'h2;
    localparam logic [7:0] SFD_OPC_114 = 8'h6B;
    localparam logic [4:0] SFD_WAIT_NONE = 5'h00;
    localparam logic [2:0] SFD_MODE_NONE = 3'h0;

    // ****************************************************************
    // wishbone register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] SFD_REG_CTRL = 8'h00;
    localparam logic [7:0] SFD_REG_STATUS = 8'h04;
    localparam logic [7:0] SFD_REG_COUNT = 8'h08;
    localparam logic [7:0] SFD_REG_QUAD = 8'h0C;
    localparam int SFD_CTRL_EN_BIT = 0;
    localparam logic SFD_CTRL_EN_RST = 1'b1;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic ce_n;
        logic sck;
        logic si;
    } sfd_pins_t;

    typedef enum logic [2:0] {
        SFD_ST_IDLE,
        SFD_ST_CMD,
        SFD_ST_ADDR,
        SFD_ST_DUMMY,
        SFD_ST_DATA,
        SFD_ST_IGNORE
    } sfd_state_t;

endpackage : sfd_pkg

// File: logic/sfd_sync.sv
// two-stage synchroniser for a bundle of asynchronous pins
// assumes the released reset copy of the system domain
`timescale 1ns/1ns
`default_nettype none
module sfd_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // pins
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ****************************************************************
    // one flop pair per pin
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            // idle high so a frame never starts out of reset
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                end else begin
                    meta_q[g] <= d_in[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign q_out = sync_q;
endmodule : sfd_sync
`default_nettype wire

// File: logic/sfd_table.sv
// read-only parameter table contents, one byte per table address
// assumes the caller holds the address stable while it reads the byte
`timescale 1ns/1ns
`default_nettype none
module sfd_table
    import sfd_pkg::*;
#(
    // arbitrary neutral value, not a real maker code
    parameter logic [7:0] VENDOR_ID = 8'h3C
) (
    input wire logic [23:0] addr_in,
    output logic [7:0] byte_out
);
    always_comb begin
        byte_out = SFD_BLANK_BYTE;
        if (addr_in <= SFD_TABLE_LAST) begin
            unique case (addr_in[5:0])
                6'h00: byte_out = 8'h53;
                6'h01: byte_out = 8'h46;
                6'h02: byte_out = 8'h44;
                6'h03: byte_out = 8'h50;
                6'h04: byte_out = 8'h00;
                6'h05: byte_out = 8'h01;
                6'h06: byte_out = 8'h01;
                6'h08: byte_out = 8'h00;
                6'h09: byte_out = 8'h00;
                6'h0A: byte_out = 8'h01;
                6'h0B: byte_out = 8'h09;
                6'h0C: byte_out = SFD_BASIC_PTR[7:0];
                6'h0D: byte_out = SFD_BASIC_PTR[15:8];
                6'h0E: byte_out = SFD_BASIC_PTR[23:16];
                6'h10: byte_out = VENDOR_ID;
                6'h11: byte_out = 8'h00;
                6'h12: byte_out = 8'h01;
                6'h13: byte_out = 8'h04;
                6'h14: byte_out = 8'h60;
                6'h15: byte_out = 8'h00;
                6'h16: byte_out = 8'h00;
                6'h30: byte_out = {SFD_RSVD_ONES, 1'b0, 1'b0, 1'b1, SFD_ERASE_4K};
                6'h31: byte_out = SFD_ERASE_OPCODE;
                6'h32: byte_out = {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, SFD_ADDRW_3B, 1'b0};
                6'h34: byte_out = 8'hFF;
                6'h35: byte_out = 8'hFF;
                6'h36: byte_out = 8'h7F;
                6'h37: byte_out = 8'h00;
                6'h38: byte_out = {SFD_MODE_144, SFD_WAIT_144};
                6'h39: byte_out = SFD_OPC_144;
                6'h3A: byte_out = {SFD_MODE_114, SFD_WAIT_114};
                6'h3B: byte_out = SFD_OPC_114;
                default: byte_out = SFD_BLANK_BYTE;
            endcase
        end
    end
endmodule : sfd_table
`default_nettype wire

// File: logic/sfd_param_table.sv
// serial responder for the discoverable-parameter table, with a wishbone control slave
// assumes serial mode 0 or 3 with the serial clock well below an eighth of 125 MHz
// Summary of operation
// - first table byte bits 1..0 read 01b; next byte holds erase opcode 20h.
// - first table byte bit 2 reads 1: program granularity 64 bytes or more.
// - first table byte bits 3 and 4 read 0: nonvolatile status register.
// - first table byte bits 7..5 read ones, so the byte returns E5h.
// - address-width bits 18..17 read 00b: three address bytes only.
// - bit 19 reads 0: no double transfer rate clocking.
// - 1-2-2, 1-4-4, 1-1-4 reads advertised; 1-1-2 read advertised absent.
// - 1-4-4 read: four wait clocks, two mode clocks, opcode EBh.
// - 1-1-4 read: eight wait clocks, two mode clocks, opcode 6Bh.
// - zero wait-state field means dummy clocks unsupported for that mode.
// - zero mode-bit field means that read mode carries no mode bits.
// - basic table pointer holds table address 30h.
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sfd_param_table
    import sfd_pkg::*;
#(
    // arbitrary neutral value, not a real maker code
    parameter logic [7:0] VENDOR_ID = 8'h3C,
    parameter int COUNT_W = 16
) (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    // serial pins
    input wire logic SPI_CE_N_IN,
    input wire logic SPI_SCK_IN,
    input wire logic SPI_SI_IN,
    output logic SPI_SO_OUT,
    output logic SPI_SO_OE_OUT,
    // wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ****************************************************************
    // pin synchronisation and edge detection
    // ****************************************************************
    sfd_pins_t pins_raw;
    sfd_pins_t pins_s;
    logic sck_dly_q;
    logic sck_rise;
    logic sck_fall;

    assign pins_raw = '{ce_n: SPI_CE_N_IN, sck: SPI_SCK_IN, si: SPI_SI_IN};

    sfd_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .d_in(pins_raw),
        .q_out(pins_s)
    );

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            sck_dly_q <= 1'b0;
        end else begin
            sck_dly_q <= pins_s.sck;
        end
    end

    // edges only count inside a frame; mode 3 idles high without a false edge
    assign sck_rise = !pins_s.ce_n && pins_s.sck && !sck_dly_q;
    assign sck_fall = !pins_s.ce_n && !pins_s.sck && sck_dly_q;

    // ****************************************************************
    // table lookup
    // ****************************************************************
    logic [23:0] addr_q;
    logic [23:0] addr_d;
    logic [7:0] tbl_byte;

    sfd_table #(
        .VENDOR_ID(VENDOR_ID)
    ) u_table (
        .addr_in(addr_q),
        .byte_out(tbl_byte)
    );

    // ****************************************************************
    // serial state machine
    // ****************************************************************
    sfd_state_t st_q;
    sfd_state_t st_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] op_q;
    logic [7:0] op_d;
    logic so_q;
    logic so_d;
    logic oe_q;
    logic oe_d;
    logic [COUNT_W-1:0] bytes_q;
    logic [COUNT_W-1:0] bytes_d;
    logic en_q;
    logic byte_start;
    logic byte_done;

    assign byte_start = sck_fall && (st_q == SFD_ST_DATA) && (cnt_q[2:0] == 3'h0);
    assign byte_done = sck_fall && (st_q == SFD_ST_DATA) && (cnt_q[2:0] == 3'h7);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        op_d = op_q;
        so_d = so_q;
        oe_d = oe_q;
        addr_d = addr_q;
        bytes_d = bytes_q;
        if (pins_s.ce_n) begin
            // chip enable high ends any frame at once
            st_d = SFD_ST_IDLE;
            cnt_d = 5'h00;
            oe_d = 1'b0;
        end else begin
            unique case (st_q)
                SFD_ST_IDLE: begin
                    st_d = SFD_ST_CMD;
                    cnt_d = 5'h00;
                end
                SFD_ST_CMD: begin
                    if (sck_rise) begin
                        sh_d = {sh_q[6:0], pins_s.si};
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == 5'(SFD_OP_BITS - 1)) begin
                            op_d = {sh_q[6:0], pins_s.si};
                            cnt_d = 5'h00;
                            if (en_q && ({sh_q[6:0], pins_s.si} == SFD_OP_READ_TABLE)) begin
                                st_d = SFD_ST_ADDR;
                            end else begin
                                st_d = SFD_ST_IGNORE;
                            end
                        end
                    end
                end
                SFD_ST_ADDR: begin
                    if (sck_rise) begin
                        addr_d = {addr_q[22:0], pins_s.si};
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == 5'(SFD_ADDR_BITS - 1)) begin
                            cnt_d = 5'h00;
                            st_d = SFD_ST_DUMMY;
                        end
                    end
                end
                SFD_ST_DUMMY: begin
                    if (sck_rise) begin
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == 5'(SFD_DUMMY_BITS - 1)) begin
                            cnt_d = 5'h00;
                            st_d = SFD_ST_DATA;
                        end
                    end
                end
                SFD_ST_DATA: begin
                    if (sck_fall) begin
                        oe_d = 1'b1;
                        cnt_d = {2'h0, cnt_q[2:0] + 3'h1};
                        // msb first; next byte fetched at the boundary
                        if (cnt_q[2:0] == 3'h0) begin
                            so_d = tbl_byte[7];
                            tx_d = {tbl_byte[6:0], 1'b1};
                        end else begin
                            so_d = tx_q[7];
                            tx_d = {tx_q[6:0], 1'b1};
                        end
                        if (cnt_q[2:0] == 3'(SFD_BYTE_BITS - 1)) begin
                            addr_d = addr_q + 24'h00_0001;
                            bytes_d = bytes_q + COUNT_W'(1);
                        end
                    end
                end
                SFD_ST_IGNORE: begin
                    st_d = SFD_ST_IGNORE;
                end
                default: begin
                    st_d = SFD_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SFD_ST_IDLE;
            cnt_q <= 5'h00;
            sh_q <= 8'h00;
            tx_q <= 8'hFF;
            op_q <= 8'h00;
            so_q <= 1'b0;
            oe_q <= 1'b0;
            addr_q <= 24'h00_0000;
            bytes_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            op_q <= op_d;
            so_q <= so_d;
            oe_q <= oe_d;
            addr_q <= addr_d;
            bytes_q <= bytes_d;
        end
    end

    assign SPI_SO_OUT = so_q;
    assign SPI_SO_OE_OUT = oe_q;

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic en_d;
    logic wb_take;
    logic wb_commit;

    // answers one cycle after the strobe, then drops ack for a cycle
    assign wb_take = WB_CYC_IN && WB_STB_IN && !ack_q;
    // a write lands at the edge where the master samples ack, not one earlier
    assign wb_commit = WB_CYC_IN && WB_STB_IN && WB_WE_IN && ack_q;

    always_comb begin
        ack_d = wb_take;
        dat_d = dat_q;
        en_d = en_q;
        if (wb_commit && (WB_ADR_IN == SFD_REG_CTRL) && WB_SEL_IN[0]) begin
            en_d = WB_DAT_IN[SFD_CTRL_EN_BIT];
        end
        if (wb_take) begin
            dat_d = 32'h0000_0000;
            if (!WB_WE_IN) begin
                unique case (WB_ADR_IN)
                    SFD_REG_CTRL: dat_d[SFD_CTRL_EN_BIT] = en_q;
                    SFD_REG_STATUS: dat_d = {16'h0000, op_q, 5'h00, st_q};
                    SFD_REG_COUNT: dat_d = 32'(bytes_q);
                    // fixed 1-1-4 and 1-4-4 table counts; no read engine uses them, writes ignored
                    SFD_REG_QUAD: dat_d = {16'h0000, SFD_MODE_114, SFD_WAIT_114,
                                           SFD_MODE_144, SFD_WAIT_144};
                    default: dat_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            en_q <= SFD_CTRL_EN_RST;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            en_q <= en_d;
        end
    end

    assign WB_ACK_OUT = ack_q;
    assign WB_DAT_OUT = dat_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!rst_n);

    sequence s_first_dw;
        byte_start && (addr_q == SFD_BASIC_PTR);
    endsequence

    sequence s_next_dw_byte;
        byte_start && (addr_q == SFD_BASIC_PTR + 24'h00_0001);
    endsequence

    a_erase_size: assert property (s_first_dw |-> tbl_byte[1:0] == 2'b01)
        else $error("erase size field wrong");
    a_erase_opcode: assert property (s_next_dw_byte |-> tbl_byte == 8'h20)
        else $error("erase opcode wrong");
    a_write_gran: assert property (s_first_dw |-> tbl_byte[2])
        else $error("write granularity bit clear");
    a_status_volat: assert property (s_first_dw |-> tbl_byte[4:3] == 2'b00)
        else $error("status volatility bits set");
    a_first_byte_val: assert property (s_first_dw |=> so_q ##0 tx_q == 8'hCB)
        else $error("first table byte is not E5h");
    a_addr_width: assert property (byte_start && addr_q == 24'h00_0032
        |-> tbl_byte[2:1] == 2'b00 && !tbl_byte[3])
        else $error("address width or dtr field wrong");
    a_read_modes: assert property (byte_start && addr_q == 24'h00_0032
        |-> tbl_byte[6:4] == 3'b111 && !tbl_byte[0])
        else $error("read mode flags wrong");
    a_quad_144: assert property (byte_start && addr_q == 24'h00_0038
        |-> tbl_byte == 8'h44)
        else $error("1-4-4 description wrong");
    a_quad_114: assert property (byte_start && addr_q == 24'h00_003A
        |-> tbl_byte == 8'h48)
        else $error("1-1-4 description wrong");
    a_table_ptr: assert property (byte_start && addr_q == 24'h00_000C
        |-> tbl_byte == 8'h30)
        else $error("table pointer wrong");
    a_msb_first: assert property (byte_start |=> so_q == $past(tbl_byte[7]) && oe_q)
        else $error("first data bit not msb");
    a_addr_incr: assert property (byte_done && !pins_s.ce_n
        |=> addr_q == $past(addr_q) + 24'h00_0001)
        else $error("address did not advance");
    a_cmd_gate: assert property (st_q == SFD_ST_CMD && sck_rise && cnt_q == 5'h07
        && !pins_s.ce_n && {sh_q[6:0], pins_s.si} != SFD_OP_READ_TABLE
        |=> st_q == SFD_ST_IGNORE)
        else $error("foreign opcode entered address phase");
    a_oe_in_frame: assert property (pins_s.ce_n |=> !oe_q ##1 st_q == SFD_ST_IDLE || !pins_s.ce_n)
        else $error("output enable outside frame");
    a_wb_ack_once: assert property (ack_q |=> !ack_q)
        else $error("ack held two cycles");
endmodule : sfd_param_table
`default_nettype wire

// File: sim/sfd_host_model.sv
// spi host model that reads the parameter table over one data line
// assumes mode 0 timing and the 125 MHz bench clock
`timescale 1ns/1ns
`default_nettype none
module sfd_host_model (
    // clock
    input wire logic clk_in,
    // serial pins
    output logic ce_n_out,
    output logic sck_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_in
);
    logic [7:0] got [0:15];
    logic oe_seen = 1'b0;
    logic ce_n_dly = 1'b1;
    initial begin
        ce_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    // cleared as each frame opens, so a refused frame reads back quiet
    always @(posedge clk_in) begin
        ce_n_dly <= ce_n_out;
        if (!ce_n_out && ce_n_dly) begin
            oe_seen <= 1'b0;
        end else if (!ce_n_out && so_oe_in === 1'b1) begin
            oe_seen <= 1'b1;
        end
    end
    // ****************************************************************
    // one frame
    // ****************************************************************
    // six-clock half periods keep sck inside the oversampling limit
    task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int n);
        logic [39:0] hdr;
        hdr = {op, adr, 8'h00};
        ce_n_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        for (int i = 0; i < 40 + 8 * n; i++) begin
            sck_out <= 1'b0;
            si_out <= (i < 40) ? hdr[39 - i] : i[0];
            repeat (6) @(posedge clk_in);
            sck_out <= 1'b1;
            if (i >= 40) begin
                // an undriven line must not pass for data
                got[(i - 40) / 8][7 - (i % 8)] = (so_oe_in === 1'b1) ? so_in : 1'bx;
            end
            repeat (6) @(posedge clk_in);
        end
        sck_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        ce_n_out <= 1'b1;
        si_out <= ~si_out;
        repeat (8) @(posedge clk_in);
    endtask : frame
endmodule : sfd_host_model
`default_nettype wire

// File: sim/sfd_param_table_tb_top.sv
// self-checking bench for the parameter table responder
// assumes the host model file is compiled first
`timescale 1ns/1ns
`default_nettype none
module sfd_param_table_tb_top;
    import sfd_pkg::*;
    localparam logic [7:0] BASIC [0:11] = '{8'hE5, 8'h20, 8'hF0, 8'hFF, 8'hFF, 8'hFF,
        8'h7F, 8'h00, 8'h44, 8'hEB, 8'h48, 8'h6B};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0000_0000;
    logic [31:0] wb_rdat;
    logic [31:0] rd;
    logic wb_ack;
    logic ce_n, sck, si, so, so_oe;
    int fails = 0;
    int n_checks = 0;
    always #4 clk_sys = ~clk_sys;
    sfd_param_table i_sfd_param_table (.CLK_SYS_IN(clk_sys), .RESET_N_IN(reset_n),
        .SPI_CE_N_IN(ce_n), .SPI_SCK_IN(sck), .SPI_SI_IN(si), .SPI_SO_OUT(so),
        .SPI_SO_OE_OUT(so_oe), .WB_CYC_IN(wb_cyc), .WB_STB_IN(wb_stb), .WB_WE_IN(wb_we),
        .WB_ADR_IN(wb_adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wb_wdat), .WB_DAT_OUT(wb_rdat),
        .WB_ACK_OUT(wb_ack));
    sfd_host_model i_sfd_host_model (.clk_in(clk_sys), .ce_n_out(ce_n), .sck_out(sck),
        .si_out(si), .so_in(so), .so_oe_in(so_oe));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int k;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (wb_ack === 1'b1) break;
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (k == 20) begin
            fails++;
            print_verdict();
        end
        @(posedge clk_sys);
    endtask : wb
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        wb(1'b0, SFD_REG_CTRL, 0);
        chk(rd, 32'h0000_0001);
        wb(1'b1, SFD_REG_QUAD, 32'h0000_0000);
        wb(1'b0, SFD_REG_QUAD, 0);
        chk(rd, 32'h0000_4844);
        // unmapped place reads zero
        wb(1'b0, 8'h40, 0);
        chk(rd, 32'h0000_0000);
    endtask : t_regs
    task automatic t_basic();
        i_sfd_host_model.frame(8'h5A, 24'h00_0030, 12);
        chk(i_sfd_host_model.got[0][1:0], 2'b01);
        chk(i_sfd_host_model.got[1], 8'h20);
        chk(i_sfd_host_model.got[0][2], 1'b1);
        chk(i_sfd_host_model.got[0][4:3], 2'b00);
        chk(i_sfd_host_model.got[0][7:5], 3'b111);
        chk(i_sfd_host_model.got[2][2:1], 2'b00);
        chk(i_sfd_host_model.got[2][3], 1'b0);
        chk({i_sfd_host_model.got[2][6:4], i_sfd_host_model.got[2][0]}, 4'hE);
        chk({i_sfd_host_model.got[8], i_sfd_host_model.got[9]}, 16'h44EB);
        chk({i_sfd_host_model.got[10], i_sfd_host_model.got[11]}, 16'h486B);
        chk(i_sfd_host_model.got[8][4:0] != 5'h00, 1);
        chk(i_sfd_host_model.got[10][7:5] != 3'h0, 1);
        for (int k = 0; k < 12; k++) begin
            chk(i_sfd_host_model.got[k], BASIC[k]);
        end
    endtask : t_basic
    task automatic t_header_wrap();
        i_sfd_host_model.frame(8'h5A, 24'h00_000C, 3);
        chk({i_sfd_host_model.got[0], i_sfd_host_model.got[1]}, 16'h3000);
        chk(i_sfd_host_model.got[2], 8'h00);
        // crossing the end of the table into blank bytes
        i_sfd_host_model.frame(8'h5A, 24'h00_003A, 4);
        chk({i_sfd_host_model.got[0], i_sfd_host_model.got[1]}, 16'h486B);
        chk({i_sfd_host_model.got[2], i_sfd_host_model.got[3]}, 16'hFFFF);
    endtask : t_header_wrap
    task automatic t_refuse();
        wb(1'b0, SFD_REG_COUNT, 0);
        chk(rd, 32'h0000_0013);
        i_sfd_host_model.frame(8'h03, 24'h00_0030, 1);
        chk(i_sfd_host_model.oe_seen, 1'b0);
        // last opcode kept, state back to idle once chip enable rose
        wb(1'b0, SFD_REG_STATUS, 0);
        chk(rd, 32'h0000_0300);
        wb(1'b1, SFD_REG_CTRL, 32'h0000_0000);
        i_sfd_host_model.frame(8'h5A, 24'h00_0030, 1);
        chk(i_sfd_host_model.oe_seen, 1'b0);
        wb(1'b1, SFD_REG_CTRL, 32'h0000_0001);
        wb(1'b0, SFD_REG_COUNT, 0);
        chk(rd, 32'h0000_0013);
        i_sfd_host_model.frame(8'h5A, 24'h00_0031, 1);
        chk(i_sfd_host_model.got[0], 8'h20);
    endtask : t_refuse
    task automatic t_reset();
        // a cleared enable must come back set after a mid-run reset
        wb(1'b1, SFD_REG_CTRL, 32'h0000_0000);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk({so_oe, wb_ack}, 2'b00);
        chk(wb_rdat, 32'h0000_0000);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        wb(1'b0, SFD_REG_CTRL, 0);
        chk(rd, 32'h0000_0001);
        wb(1'b0, SFD_REG_COUNT, 0);
        chk(rd, 32'h0000_0000);
        i_sfd_host_model.frame(8'h5A, 24'h00_0030, 1);
        chk(i_sfd_host_model.got[0], 8'hE5);
    endtask : t_reset
    initial begin
        repeat (16) @(posedge clk_sys);
        chk({so_oe, wb_ack}, 2'b00);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_regs();
        t_basic();
        t_header_wrap();
        t_refuse();
        t_reset();
        print_verdict();
    end
endmodule : sfd_param_table_tb_top
`default_nettype wire
